// ---- rtl/pcxi_pkg.sv ----
// Purpose: Shared constants and types for the pin change and external interrupt flag block.
// Assumes: Classic Wishbone with 32-bit data, byte addresses, one register per aligned word.
// Notes:   Printed offsets are not all multiples of four, so they are word indices.
package pcxi_pkg;
    localparam int        ADDR_W          = 12;
    localparam int        NUM_GROUPS      = 4;
    localparam int        PINS_PER_GROUP  = 8;
    localparam int        NUM_PINS        = 31;

    // Register indices; byte address is four times the index.
    localparam logic [9:0] IDX_MASK0      = 10'h06b;
    localparam logic [9:0] IDX_MASK1      = 10'h06c;
    localparam logic [9:0] IDX_MASK2      = 10'h06d;
    localparam logic [9:0] IDX_MASK3      = 10'h06e;
    localparam logic [9:0] IDX_FLAGS      = 10'h01c;
    localparam logic [9:0] IDX_ENABLES    = 10'h01d;
    localparam logic [9:0] IDX_SENSE      = 10'h069;
    localparam logic [9:0] IDX_PINS       = 10'h070;

    // Field positions in the flag and enable registers.
    localparam int        BIT_EXT         = 0;
    localparam int        BIT_GROUP0      = 4;

    localparam logic [7:0] RST_MASK       = 8'h00;
    localparam logic [7:0] RST_ENABLES    = 8'h00;
    localparam logic [7:0] RST_FLAGS      = 8'h00;
    localparam logic [1:0] RST_SENSE      = 2'h0;
    localparam logic [7:0] GROUP_BITS     = 8'hf0;
    localparam logic [7:0] SMALL_HIDE     = 8'h3f;
    localparam logic [6:0] GROUP3_WIDTH_M = 7'h7f;

    // Sense select encoding.
    typedef enum logic [1:0] {
        PCXI_SENSE_LOW  = 2'h0,
        PCXI_SENSE_ANY  = 2'h1,
        PCXI_SENSE_FALL = 2'h2,
        PCXI_SENSE_RISE = 2'h3
    } pcxi_sense_e;

    // Bus handshake state; Gray coded along idle, answer.
    typedef enum logic [0:0] {
        PCXI_BUS_IDLE = 1'h0,
        PCXI_BUS_ACK  = 1'h1
    } pcxi_bus_state_e;

    // Interrupt vector requests and acknowledges travel together.
    typedef struct packed {
        logic [3:0] group;
        logic       ext;
    } pcxi_irq_s;
endpackage : pcxi_pkg

// ---- rtl/pcxi_mask_regs.sv ----
// Purpose: Storage for the four per-group pin mask registers with registered read data.
// Assumes: One write port, one read port, both on clk_i.
// Notes:   Group 3 mask holds seven bits only; bit 7 reads zero.
`timescale 1ns/1ps
module pcxi_mask_regs
    import pcxi_pkg::*;
(
    // Clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    // Write port
    input  wire logic                   wr_en_i,
    input  wire logic [1:0]             wr_sel_i,
    input  wire logic [7:0]             wr_data_i,
    // Read port
    input  wire logic [1:0]             rd_sel_i,
    output logic      [7:0]             rd_data_o,
    // All masks flat, group 0 in the low byte
    output logic      [31:0]            masks_o
);
    logic [7:0] mask_ff     [NUM_GROUPS];
    logic [7:0] nxt_mask    [NUM_GROUPS];
    logic [7:0] rd_ff;
    logic [7:0] nxt_rd;

    for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_mask
        always_comb begin
            nxt_mask[g] = mask_ff[g];
            if (wr_en_i && wr_sel_i == 2'(g)) begin
                nxt_mask[g] = (g == NUM_GROUPS - 1)
                            ? {1'b0, wr_data_i[6:0] & GROUP3_WIDTH_M}
                            : wr_data_i;
            end
        end
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                mask_ff[g] <= RST_MASK;
            end else begin
                mask_ff[g] <= nxt_mask[g];
            end
        end
        assign masks_o[g*PINS_PER_GROUP +: PINS_PER_GROUP] = mask_ff[g];
    end

    always_comb begin
        nxt_rd = mask_ff[rd_sel_i];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_ff <= RST_MASK;
        end else begin
            rd_ff <= nxt_rd;
        end
    end

    assign rd_data_o = rd_ff;
endmodule : pcxi_mask_regs

// ---- rtl/pcxi_irq_ctrl.sv ----
// Purpose: Flags, enables and sense control for one external input and four pin change groups.
// Assumes: Pins synchronous to clk_i; vector acknowledges come from the dispatch logic.
// Notes:   LARGE_VARIANT = 0 gives the smaller part with groups 3 and 2 removed.
//
// Added by the designer: the Wishbone slave port.
`timescale 1ns/1ps
module pcxi_irq_ctrl
    import pcxi_pkg::*;
#(
    parameter bit LARGE_VARIANT = 1'b1
)(
    // Clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    // Classic Wishbone slave
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    input  wire logic                   wb_we_i,
    input  wire logic [ADDR_W-1:0]      wb_adr_i,
    input  wire logic [3:0]             wb_sel_i,
    input  wire logic [31:0]            wb_dat_i,
    output logic      [31:0]            wb_dat_o,
    output logic                        wb_ack_o,
    // Pins
    input  wire logic [NUM_PINS-1:0]    pc_pins_i,
    input  wire logic                   ext_input_i,
    // Processor dispatch
    input  wire logic                   global_irq_en_i,
    input  wire pcxi_irq_s              irq_ack_i,
    output pcxi_irq_s                   irq_req_o,
    output logic                        wake_o
);
    localparam logic [7:0] FLAG_VIS = LARGE_VARIANT ? 8'hff : SMALL_HIDE;

    // Bus decode.
    logic [9:0]         word_idx;
    logic               bus_req;
    logic               wr_lane0;
    logic               hit_mask;
    logic [1:0]         mask_sel;
    logic               mask_present;
    pcxi_bus_state_e    bus_st_ff;
    pcxi_bus_state_e    nxt_bus_st;
    logic [9:0]         rd_idx_ff;
    logic [9:0]         nxt_rd_idx;
    logic [7:0]         mask_rd;
    logic [31:0]        masks;
    logic [31:0]        dat_ff;
    logic [31:0]        nxt_dat;

    // Control and state.
    logic [7:0]         enables_ff;
    logic [7:0]         nxt_enables;
    pcxi_sense_e        sense_ff;
    pcxi_sense_e        nxt_sense;
    logic [7:0]         flags_ff;
    logic [7:0]         nxt_flags;
    logic [NUM_PINS-1:0] pins_prev_ff;
    logic [NUM_PINS-1:0] nxt_pins_prev;
    logic               ext_samp_ff;
    logic               nxt_ext_samp;
    logic               ext_prev_ff;
    logic               nxt_ext_prev;
    logic [3:0]         grp_event;
    logic               ext_event;
    logic [7:0]         set_vec;
    logic [7:0]         clr_vec;
    logic [31:0]        pins_pad;
    logic [31:0]        prev_pad;

    assign word_idx = wb_adr_i[ADDR_W-1:2];
    assign bus_req  = wb_cyc_i && wb_stb_i && (bus_st_ff == PCXI_BUS_IDLE);
    assign wr_lane0 = bus_req && wb_we_i && wb_sel_i[0];
    assign hit_mask = (word_idx == IDX_MASK0) || (word_idx == IDX_MASK1)
                   || (word_idx == IDX_MASK2) || (word_idx == IDX_MASK3);
    assign mask_sel = 2'(word_idx - IDX_MASK0);
    assign mask_present = LARGE_VARIANT || (mask_sel < 2'h2);

    // One wait state: request taken at edge N, ack high the cycle after.
    always_comb begin
        nxt_bus_st = PCXI_BUS_IDLE;
        nxt_rd_idx = rd_idx_ff;
        case (bus_st_ff)
            PCXI_BUS_IDLE: begin
                if (bus_req) begin
                    nxt_bus_st = PCXI_BUS_ACK;
                    nxt_rd_idx = word_idx;
                end
            end
            PCXI_BUS_ACK: nxt_bus_st = PCXI_BUS_IDLE;
            default:      nxt_bus_st = PCXI_BUS_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_st_ff <= PCXI_BUS_IDLE;
            rd_idx_ff <= 10'h000;
        end else begin
            bus_st_ff <= nxt_bus_st;
            rd_idx_ff <= nxt_rd_idx;
        end
    end

    assign wb_ack_o = (bus_st_ff == PCXI_BUS_ACK);

    pcxi_mask_regs u_masks (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .wr_en_i   (wr_lane0 && hit_mask && mask_present),
        .wr_sel_i  (mask_sel),
        .wr_data_i (wb_dat_i[7:0]),
        .rd_sel_i  (mask_sel),
        .rd_data_o (mask_rd),
        .masks_o   (masks)
    );

    // Read data is captured in the same cycle as the mask read register.
    always_comb begin
        nxt_dat = dat_ff;
        if (bus_req && !wb_we_i) begin
            nxt_dat = 32'h0000_0000;
            case (word_idx)
                IDX_FLAGS:   nxt_dat[7:0] = flags_ff & FLAG_VIS;
                IDX_ENABLES: nxt_dat[7:0] = enables_ff;
                IDX_SENSE:   nxt_dat[1:0] = sense_ff;
                IDX_PINS:    nxt_dat[NUM_PINS-1:0] = pc_pins_i;
                default:     nxt_dat = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_ff <= 32'h0000_0000;
        end else begin
            dat_ff <= nxt_dat;
        end
    end

    // Mask data arrives from the memory register during the ack cycle.
    always_comb begin
        wb_dat_o = dat_ff;
        if (wb_ack_o && ((rd_idx_ff == IDX_MASK0) || (rd_idx_ff == IDX_MASK1)
                || (rd_idx_ff == IDX_MASK2) || (rd_idx_ff == IDX_MASK3))) begin
            wb_dat_o = 32'h0000_0000;
            if (LARGE_VARIANT || rd_idx_ff < IDX_MASK2) begin
                wb_dat_o[7:0] = mask_rd;
            end
        end
    end

    // Enable and sense control registers.
    always_comb begin
        nxt_enables = enables_ff;
        nxt_sense   = sense_ff;
        if (wr_lane0 && word_idx == IDX_ENABLES) begin
            nxt_enables = wb_dat_i[7:0] & GROUP_BITS & FLAG_VIS;
            nxt_enables[BIT_EXT] = wb_dat_i[BIT_EXT];
        end
        if (wr_lane0 && word_idx == IDX_SENSE) begin
            nxt_sense = pcxi_sense_e'(wb_dat_i[1:0]);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            enables_ff <= RST_ENABLES;
            sense_ff   <= PCXI_SENSE_LOW;
        end else begin
            enables_ff <= nxt_enables;
            sense_ff   <= nxt_sense;
        end
    end

    // Pin change detection: masked sample against the previous sample, per group.
    assign pins_pad = {1'b0, pc_pins_i};
    assign prev_pad = {1'b0, pins_prev_ff};

    for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_detect
        // Group enable gates the masks, so a disabled group never sets its flag.
        assign grp_event[g] = enables_ff[BIT_GROUP0 + g] && FLAG_VIS[BIT_GROUP0 + g]
            && |((pins_pad[g*8 +: 8] ^ prev_pad[g*8 +: 8]) & masks[g*8 +: 8]);
    end

    // The pins are already synchronous, so one sample stage suffices for edge detection.
    always_comb begin
        ext_event = 1'b0;
        case (sense_ff)
            PCXI_SENSE_ANY:  ext_event = ext_samp_ff ^ ext_prev_ff;
            PCXI_SENSE_FALL: ext_event = ext_prev_ff && !ext_samp_ff;
            PCXI_SENSE_RISE: ext_event = !ext_prev_ff && ext_samp_ff;
            default:         ext_event = 1'b0;
        endcase
    end

    always_comb begin
        set_vec = 8'h00;
        clr_vec = 8'h00;
        set_vec[7:BIT_GROUP0] = grp_event;
        set_vec[BIT_EXT] = ext_event;
        clr_vec[7:BIT_GROUP0] = irq_ack_i.group;
        clr_vec[BIT_EXT] = irq_ack_i.ext;
        if (wr_lane0 && word_idx == IDX_FLAGS) begin
            clr_vec = clr_vec | wb_dat_i[7:0];
        end
        nxt_flags = ((flags_ff & ~clr_vec) | set_vec) & FLAG_VIS & (GROUP_BITS | 8'h01);
        if (sense_ff == PCXI_SENSE_LOW) begin
            nxt_flags[BIT_EXT] = 1'b0;
        end
        nxt_pins_prev = pc_pins_i;
        nxt_ext_samp  = ext_input_i;
        nxt_ext_prev  = ext_samp_ff;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_ff     <= RST_FLAGS;
            pins_prev_ff <= '0;
            ext_samp_ff  <= 1'b0;
            ext_prev_ff  <= 1'b0;
        end else begin
            flags_ff     <= nxt_flags;
            pins_prev_ff <= nxt_pins_prev;
            ext_samp_ff  <= nxt_ext_samp;
            ext_prev_ff  <= nxt_ext_prev;
        end
    end

    // Low level requests come from the sampled pin level in ext_samp_ff, without a flag.
    always_comb begin
        irq_req_o.group = flags_ff[7:BIT_GROUP0] & enables_ff[7:BIT_GROUP0]
                        & {4{global_irq_en_i}};
        irq_req_o.ext = global_irq_en_i && enables_ff[BIT_EXT]
            && ((sense_ff == PCXI_SENSE_LOW) ? !ext_samp_ff : flags_ff[BIT_EXT]);
    end

    // Wake does not wait for the flag register, so a stopped core sees it at once.
    assign wake_o = |grp_event
        || (enables_ff[BIT_EXT] && sense_ff == PCXI_SENSE_LOW && !ext_input_i);
endmodule : pcxi_irq_ctrl

// ---- testbench/pcxi_irq_ctrl_sva.sv ----
// Purpose: Port assertions for the interrupt flag block.
// Assumes: One clock, synchronous active-high reset.
// Notes:   A pin change reaches the request outputs one edge later.
`timescale 1ns/1ps
module pcxi_irq_ctrl_sva
    import pcxi_pkg::*;
(
    // Clock, reset and bus
    input wire logic                clk_i,
    input wire logic                rst_i,
    input wire logic                wb_cyc_i,
    input wire logic                wb_stb_i,
    input wire logic                wb_we_i,
    input wire logic [31:0]         wb_dat_o,
    input wire logic                wb_ack_o,
    // Pins and dispatch
    input wire logic [NUM_PINS-1:0] pc_pins_i,
    input wire logic                ext_input_i,
    input wire logic                global_irq_en_i,
    input wire pcxi_irq_s           irq_ack_i,
    input wire pcxi_irq_s           irq_req_o,
    input wire logic                wake_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_ack_wait: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o)
        else $error("ack not one cycle after request");
    chk_ack_cause: assert property (wb_ack_o |-> $past(wb_stb_i) && wb_cyc_i && wb_stb_i)
        else $error("ack without request");
    chk_req_global: assert property (!global_irq_en_i |-> irq_req_o == '0)
        else $error("request while globally disabled");
    // Pins held still around the service pulse, so no new set can mask the clear.
    chk_ack_clears: assert property (irq_ack_i.group[1] && !wb_cyc_i && !$past(wb_cyc_i)
        && $stable(pc_pins_i) && pc_pins_i == $past(pc_pins_i, 2) |=> !irq_req_o.group[1])
        else $error("serviced flag not cleared");
    chk_quiet_pins: assert property ($rose(irq_req_o.group[1]) && $stable(global_irq_en_i)
        && !$past(wb_cyc_i) && !$past(wb_cyc_i, 2) && !$past(wb_cyc_i, 3)
        |-> $past(pc_pins_i) != $past(pc_pins_i, 2))
        else $error("request without pin change");
    chk_req_hold: assert property (irq_req_o.group[1] && !irq_ack_i.group[1] && !wb_cyc_i
        |=> irq_req_o.group[1] || !global_irq_en_i)
        else $error("flag lost without clear");
    chk_wake_quiet: assert property (ext_input_i && !$past(wb_cyc_i) && !wb_cyc_i
        && $stable(pc_pins_i) && pc_pins_i == $past(pc_pins_i, 2) |-> !wake_o)
        else $error("wake without cause");

    cover property (wb_ack_o && wb_we_i);
    cover property (irq_ack_i.group[1]);
    cover property ($rose(wake_o));
endmodule : pcxi_irq_ctrl_sva

bind pcxi_irq_ctrl pcxi_irq_ctrl_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .pc_pins_i(pc_pins_i), .ext_input_i(ext_input_i), .global_irq_en_i(global_irq_en_i),
    .irq_ack_i(irq_ack_i), .irq_req_o(irq_req_o), .wake_o(wake_o));

// ---- testbench/pcxi_dispatch_model.sv ----
// Purpose: Behavioural dispatch logic that services vector requests.
// Assumes: Requests are levels; one acknowledge pulse per service.
// Notes:   A small shift register varies the answer delay.
`timescale 1ns/1ps
module pcxi_dispatch_model
    import pcxi_pkg::*;
(
    // Clock and reset
    input  wire logic      clk_i,
    input  wire logic      rst_i,
    // Service enable and vector handshake
    input  wire logic      en_i,
    input  wire pcxi_irq_s req_i,
    output pcxi_irq_s      ack_o
);
    logic [2:0] lfsr_ff;
    logic [2:0] nxt_lfsr;
    pcxi_irq_s  ack_ff;
    pcxi_irq_s  nxt_ack;

    always_comb begin
        nxt_lfsr = {lfsr_ff[1:0], lfsr_ff[2] ^ lfsr_ff[1]};
        // No second pulse in a row: the flag only drops after the first one lands.
        nxt_ack  = (en_i && lfsr_ff[0]) ? (req_i & ~ack_ff) : '0;
    end

    always_ff @(posedge clk_i) begin
        lfsr_ff <= rst_i ? 3'h1 : nxt_lfsr;
        ack_ff  <= rst_i ? '0 : nxt_ack;
    end

    assign ack_o = ack_ff;
endmodule : pcxi_dispatch_model

// ---- testbench/pcxi_irq_ctrl_tb.sv ----
// Purpose: Self-checking bench for the interrupt flag block.
// Assumes: Large variant; registers at four times their word index.
// Notes:   Fixed waits follow the one-edge pin flag and two-edge external flag latency of the block.
`timescale 1ns/1ps
module pcxi_irq_ctrl_tb import pcxi_pkg::*;;
    logic                clk_i = 1'b0;
    logic                rst_i = 1'b1;
    logic                cyc = 1'b0;
    logic                stb = 1'b0;
    logic                we = 1'b0;
    logic [ADDR_W-1:0]   adr = '0;
    logic [3:0]          sel = 4'h0;
    logic [31:0]         wdat = '0;
    logic [31:0]         q;
    logic [31:0]         q_s;
    logic [31:0]         dat_s;
    logic [NUM_PINS-1:0] pins = '0;
    logic                ext = 1'b1;
    logic                gie = 1'b0;
    logic                srv_en = 1'b0;
    logic [31:0]         wb_dat_o;
    logic                wb_ack_o;
    logic                wake;
    logic [7:0]          m;
    pcxi_irq_s           ack;
    pcxi_irq_s           req;
    int                  miscompares = 0;
    int                  n_checks = 0;
    int                  cycles = 0;

    pcxi_irq_ctrl #(.LARGE_VARIANT(1'b1)) DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pc_pins_i(pins), .ext_input_i(ext),
        .global_irq_en_i(gie), .irq_ack_i(ack), .irq_req_o(req), .wake_o(wake));
    // The small variant shadows the same bus, so its hidden bits are read in lockstep.
    pcxi_irq_ctrl #(.LARGE_VARIANT(1'b0)) DUT_S (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(dat_s), .wb_ack_o(), .pc_pins_i(pins), .ext_input_i(ext),
        .global_irq_en_i(gie), .irq_ack_i(ack), .irq_req_o(), .wake_o());
    pcxi_dispatch_model u_disp (.clk_i(clk_i), .rst_i(rst_i), .en_i(srv_en), .req_i(req),
        .ack_o(ack));

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    function automatic logic [31:0] exp_flag(input int g);
        return 32'h10 << g;
    endfunction : exp_flag

    function automatic logic [31:0] exp_ext(input int s, input logic r);
        return {31'h0, (s == 1) || (s == 2 && !r) || (s == 3 && r)};
    endfunction : exp_ext

    task automatic wb(input logic w, input logic [9:0] i, input logic [7:0] d);
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        sel  <= 4'h1;
        adr  <= {i, 2'h0};
        wdat <= {24'h0, d};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        q_s = dat_s;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic rd(input logic [9:0] i, input logic [31:0] exp);
        wb(1'b0, i, 8'h00);
        chk(q, exp);
    endtask : rd

    task automatic drive(input logic [NUM_PINS-1:0] v, input logic e);
        @(posedge clk_i);
        pins <= v;
        ext  <= e;
        repeat (4) @(posedge clk_i);
    endtask : drive

    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            stop_test();
        end
    end

    initial begin
        logic [9:0] regs [8] = '{IDX_MASK0, IDX_MASK1, IDX_MASK2, IDX_MASK3, IDX_FLAGS,
                                 IDX_ENABLES, IDX_SENSE, 10'h3ff};
        void'($urandom(32'h5b0dc13e));
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (regs[i]) rd(regs[i], 32'h0);
        wb(1'b1, 10'h3ff, 8'hff);
        rd(10'h3ff, 32'h0);
        $display("test reset done");
        for (int g = 0; g < 4; g++) begin
            m = 8'($urandom) | 8'h01;
            wb(1'b1, 10'(IDX_MASK0 + g), m);
            rd(10'(IDX_MASK0 + g), {24'h0, (g == 3) ? (m & 8'h7f) : m});
            chk(q_s, {24'h0, (g < 2) ? m : 8'h00});
            wb(1'b1, IDX_ENABLES, 8'h00);
            drive(pins ^ (31'(m) << (8 * g)), ext);
            rd(IDX_FLAGS, 32'h0);
            wb(1'b1, IDX_ENABLES, 8'(8'h10 << g));
            drive(pins ^ (31'(~m) << (8 * g)), ext);
            rd(IDX_FLAGS, 32'h0);
            @(posedge clk_i);
            pins <= pins ^ (31'(m) << (8 * g));
            @(posedge clk_i);
            chk({31'h0, wake}, 32'h1);
            repeat (3) @(posedge clk_i);
            chk({31'h0, wake}, 32'h0);
            rd(IDX_FLAGS, exp_flag(g));
            chk(q_s, (g < 2) ? exp_flag(g) : 32'h0);
            wb(1'b1, IDX_FLAGS, 8'h00);
            rd(IDX_FLAGS, exp_flag(g));
            wb(1'b1, IDX_FLAGS, 8'(exp_flag(g)));
            rd(IDX_FLAGS, 32'h0);
        end
        $display("test groups done");
        for (int s = 0; s < 4; s++) begin
            wb(1'b1, IDX_SENSE, 8'(s));
            wb(1'b1, IDX_FLAGS, 8'hff);
            for (int r = 0; r < 2; r++) begin
                drive(pins, r[0]);
                rd(IDX_FLAGS, exp_ext(s, r[0]));
                wb(1'b1, IDX_FLAGS, 8'h01);
            end
        end
        $display("test sense done");
        wb(1'b1, IDX_MASK1, 8'hff);
        wb(1'b1, IDX_ENABLES, 8'h20);
        gie <= 1'b1;
        drive(pins ^ 31'h100, ext);
        chk(32'(req), 32'h4);
        gie <= 1'b0;
        @(posedge clk_i);
        chk(32'(req), 32'h0);
        gie    <= 1'b1;
        srv_en <= 1'b1;
        repeat (6) drive(pins ^ ((31'($urandom) & 31'h0000ff00) | 31'h100), ext);
        repeat (8) @(posedge clk_i);
        rd(IDX_FLAGS, 32'h0);
        wb(1'b1, IDX_SENSE, 8'h00);
        wb(1'b1, IDX_ENABLES, 8'h01);
        drive(pins, 1'b0);
        chk(32'(req), 32'h1);
        chk({31'h0, wake}, 32'h1);
        drive(pins, 1'b1);
        chk(32'(req), 32'h0);
        $display("test dispatch done");
        stop_test();
    end
endmodule : pcxi_irq_ctrl_tb
